// *** pst_segment_trigger.sv ***
// Module: process segment command, edge trigger and limit check logic
`timescale 1ns/1ps
// Notes on behaviour
// - Command value 0 starts homing
// - Command 1 to 15 starts that segment
// - Command 1000 pauses the running segment
// - Command 16 to 999 raises number fault
// - Read returns segment number while executing
// - Commands done: read returns number plus 10000
// - Done and in position: plus 20000
// - Rising selector nibbles start segment on rise
// - Zero rising nibble causes no start
// - Falling selector nibbles start segment on fall
// - Zero falling nibble ignores the edge
// - Pause ramps using one of eight settings
// - Forward reference beyond limit raises overtravel while a segment is positioning
// - Link and keypad share one command decoder
// - Ramp time means ms per 1000 rpm
module pst_segment_trigger (
    input  wire logic                       clk_sys,
    input  wire logic                       reset_n,
    input  wire pst_pkg::pst_param_req_t    param_req,
    input  wire pst_pkg::pst_cmd_t          keypad_cmd,
    input  wire logic [3:0]                 segment_event_trigger_input,
    input  wire logic                       pos_cmds_done,
    input  wire logic                       positioning_complete,
    input  wire logic                       segment_positioning,
    input  wire logic [31:0]                position_ref,
    input  wire logic                       fault_clear,
    output logic [31:0]                     param_rdata_r,
    output logic                            param_rd_valid_r,
    output logic                            param_addr_err_r,
    output pst_pkg::pst_motion_req_t        motion_req_r,
    output logic [2:0]                      pause_ramp_sel_r,
    output logic [3:0]                      active_seg_r,
    output logic                            segment_number_error_fault_r,
    output logic                            positive_overtravel_fault_r
);

    // ------
    // Declarations
    // ------
    // All of it runs on clk_sys
    logic [15:0] rise_sel_r;          // Rising-edge selector nibbles
    logic [15:0] fall_sel_r;          // Falling-edge selector nibbles
    logic [2:0]  ramp_sel_r;          // Pause ramp selector
    logic [31:0] pos_limit_r;         // Positive software limit
    logic [3:0]  trig_meta_r;         // First synchroniser stage
    logic [3:0]  trig_sync_r;         // Second synchroniser stage
    logic [3:0]  trig_prev_r;         // Last synchronised level
    logic [3:0]  pend_rise_r;         // Rising edges waiting for service
    logic [3:0]  pend_fall_r;         // Falling edges waiting for service
    logic [3:0]  rise_edge;           // Qualified rising edges
    logic [3:0]  fall_edge;           // Qualified falling edges
    logic [3:0]  serve_rise;          // One-hot rising edge served now
    logic [3:0]  serve_fall;          // One-hot falling edge served now
    logic [3:0]  trig_seg;            // Segment of the served edge
    logic        trig_valid;          // An edge is served this cycle
    pst_pkg::pst_cmd_t host_cmd;      // Command written by the link
    pst_pkg::pst_cmd_t dec_cmd;       // Command given to the decoder
    logic        dec_homing;          // Decoded homing request
    logic        dec_start;           // Decoded numbered start
    logic        dec_pause;           // Decoded pause
    logic        dec_numerr;          // Decoded illegal number
    logic [3:0]  start_num;           // Segment to start
    logic        start_any;           // Any start this cycle
    logic [15:0] state_word;          // Readback of the command register
    logic        overtravel;          // Reference beyond the limit

    // ------
    // Trigger input synchroniser
    // ------
    // Reset low like idle pins
    // Pins are asynchronous; two stages before any edge logic.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            trig_meta_r <= 4'h0;
            trig_sync_r <= 4'h0;
            trig_prev_r <= 4'h0;
        end else begin
            trig_meta_r <= segment_event_trigger_input;
            trig_sync_r <= trig_meta_r;
            trig_prev_r <= trig_sync_r;
        end
    end

    // ------
    // Edge qualification
    // ------
    // Nibble i is input i+1
    // A zero selector nibble discards the edge before it can queue.
    always_comb begin
        for (int i = 0; i < pst_pkg::NUM_TRIGGERS; i++) begin
            // Off to on with a live nibble
            rise_edge[i] = trig_sync_r[i] && !trig_prev_r[i]
                && (rise_sel_r[i*pst_pkg::SEL_FIELD_W +: 4] != 4'h0);
            // On to off with a live nibble
            fall_edge[i] = !trig_sync_r[i] && trig_prev_r[i]
                && (fall_sel_r[i*pst_pkg::SEL_FIELD_W +: 4] != 4'h0);
        end
    end

    // ------
    // Pending edge arbitration
    // ------
    // Input 1 first, rise first
    // Edges that coincide with each other or with a direct command are
    // held and start later; a repeat edge on the same pin and direction while held merges into one start.
    always_comb begin
        serve_rise = 4'h0;
        serve_fall = 4'h0;
        trig_seg   = 4'h0;
        trig_valid = 1'b0;
        for (int i = pst_pkg::NUM_TRIGGERS - 1; i >= 0; i--) begin
            if (pend_fall_r[i]) begin
                serve_rise = 4'h0;
                serve_fall = 4'h1 << i;
                trig_seg   = fall_sel_r[i*pst_pkg::SEL_FIELD_W +: 4];
                trig_valid = 1'b1;
            end
            if (pend_rise_r[i]) begin
                serve_fall = 4'h0;
                serve_rise = 4'h1 << i;
                trig_seg   = rise_sel_r[i*pst_pkg::SEL_FIELD_W +: 4];
                trig_valid = 1'b1;
            end
        end
        // Direct commands take the cycle; the edge waits
        if (dec_cmd.valid) begin
            serve_rise = 4'h0;
            serve_fall = 4'h0;
            trig_valid = 1'b0;
        end
    end

    // Queue bits: a new edge wins over its own service clear
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pend_rise_r <= 4'h0;
            pend_fall_r <= 4'h0;
        end else begin
            pend_rise_r <= (pend_rise_r & ~serve_rise) | rise_edge;
            pend_fall_r <= (pend_fall_r & ~serve_fall) | fall_edge;
        end
    end

    // ------
    // Command sources
    // ------
    // On a tie the keypad is lost
    // Link write to the command word, else keypad; one decoder.
    always_comb begin
        host_cmd.valid = param_req.wr
            && (param_req.addr == pst_pkg::ADDR_SEGMENT_COMMAND_STATE);
        host_cmd.value = param_req.wdata[15:0];
        dec_cmd        = host_cmd.valid ? host_cmd : keypad_cmd;
    end

    // ------
    // Command decoder
    // ------
    // Unsigned compares
    // Values above the pause code are outside the range and do nothing.
    always_comb begin
        dec_homing = 1'b0;
        dec_start  = 1'b0;
        dec_pause  = 1'b0;
        dec_numerr = 1'b0;
        if (dec_cmd.valid) begin
            if (dec_cmd.value == pst_pkg::CMD_HOMING) begin
                dec_homing = 1'b1;
            end else if (dec_cmd.value <= pst_pkg::CMD_SEG_LAST) begin
                dec_start  = 1'b1;
            end else if (dec_cmd.value <= pst_pkg::CMD_ERR_LAST) begin
                dec_numerr = 1'b1;
            end else if (dec_cmd.value == pst_pkg::CMD_PAUSE) begin
                dec_pause  = 1'b1;
            end
        end
        start_any = dec_start || trig_valid;
        start_num = dec_start ? dec_cmd.value[3:0] : trig_seg;
    end

    // ------
    // Motion request outputs
    // ------
    // Number is zero off a start
    // Every request is a single-cycle pulse.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            motion_req_r <= '0;
        end else begin
            motion_req_r.homing  <= dec_homing;
            motion_req_r.start   <= start_any;
            motion_req_r.pause   <= dec_pause;
            motion_req_r.seg_num <= start_any ? start_num : 4'h0;
        end
    end

    // Pause ramp index sampled with the pause so a later write cannot
    // change a ramp already in progress. The motion generator reads the
    // selected time as ms per RAMP_REF_RPM rpm of speed change.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pause_ramp_sel_r <= pst_pkg::RST_PAUSE_RAMP_SELECT;
        end else if (dec_pause) begin
            pause_ramp_sel_r <= ramp_sel_r;
        end
    end

    // Segment number now in progress; homing reports zero
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            active_seg_r <= 4'h0;
        end else if (dec_homing) begin
            active_seg_r <= 4'h0;
        end else if (start_any) begin
            active_seg_r <= start_num;
        end
    end

    // ------
    // Faults
    // ------
    // One clear for both faults
    // Sticky; an event in the clearing cycle keeps the fault set.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            segment_number_error_fault_r <= 1'b0;
        end else if (dec_numerr) begin
            segment_number_error_fault_r <= 1'b1;
        end else if (fault_clear) begin
            segment_number_error_fault_r <= 1'b0;
        end
    end

    // Signed compare; only checked while a segment positions
    assign overtravel = segment_positioning
        && ($signed(position_ref) > $signed(pos_limit_r));

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            positive_overtravel_fault_r <= 1'b0;
        end else if (overtravel) begin
            positive_overtravel_fault_r <= 1'b1;
        end else if (fault_clear) begin
            positive_overtravel_fault_r <= 1'b0;
        end
    end

    // ------
    // Parameter registers
    // ------
    // Writes act at once
    // The command word is not stored; a write is a command only.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rise_sel_r  <= pst_pkg::RST_RISING_EDGE_SELECT;
            fall_sel_r  <= pst_pkg::RST_FALLING_EDGE_SELECT;
            ramp_sel_r  <= pst_pkg::RST_PAUSE_RAMP_SELECT;
            pos_limit_r <= pst_pkg::RST_POSITIVE_POSITION_LIMIT;
        end else if (param_req.wr) begin
            unique case (param_req.addr)
                pst_pkg::ADDR_RISING_EDGE_SEGMENT_SELECT: begin
                    rise_sel_r <= param_req.wdata[15:0];
                end
                pst_pkg::ADDR_FALLING_EDGE_SEGMENT_SELECT: begin
                    fall_sel_r <= param_req.wdata[15:0];
                end
                pst_pkg::ADDR_PAUSE_RAMP_SELECT: begin
                    // Out-of-range selectors are refused, value kept
                    if (param_req.wdata[15:0] <= pst_pkg::RAMP_SEL_MAX) begin
                        ramp_sel_r <= param_req.wdata[2:0];
                    end
                end
                pst_pkg::ADDR_POSITIVE_POSITION_LIMIT: begin
                    pos_limit_r <= param_req.wdata;
                end
                default: begin
                    // Command word and unmapped addresses store nothing
                end
            endcase
        end
    end

    // ------
    // Command register readback
    // ------
    // Offsets ride on live levels
    // In-position without commands done cannot occur; done governs.
    always_comb begin
        if (pos_cmds_done && positioning_complete) begin
            state_word = {12'h000, active_seg_r}
                + pst_pkg::STATE_OFS_INPOS;
        end else if (pos_cmds_done) begin
            state_word = {12'h000, active_seg_r}
                + pst_pkg::STATE_OFS_DONE;
        end else begin
            state_word = {12'h000, active_seg_r};
        end
    end

    // ------
    // Read port
    // ------
    // No wait states on reads
    // Data one cycle after the read strobe; unmapped reads give zero.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            param_rdata_r    <= 32'h00000000;
            param_rd_valid_r <= 1'b0;
            param_addr_err_r <= 1'b0;
        end else begin
            param_rd_valid_r <= param_req.rd;
            param_addr_err_r <= 1'b0;
            param_rdata_r    <= 32'h00000000;
            if (param_req.rd) begin
                unique case (param_req.addr)
                    pst_pkg::ADDR_SEGMENT_COMMAND_STATE: begin
                        param_rdata_r <= {16'h0000, state_word};
                    end
                    pst_pkg::ADDR_RISING_EDGE_SEGMENT_SELECT: begin
                        param_rdata_r <= {16'h0000, rise_sel_r};
                    end
                    pst_pkg::ADDR_FALLING_EDGE_SEGMENT_SELECT: begin
                        param_rdata_r <= {16'h0000, fall_sel_r};
                    end
                    pst_pkg::ADDR_PAUSE_RAMP_SELECT: begin
                        param_rdata_r <= {29'h00000000, ramp_sel_r};
                    end
                    pst_pkg::ADDR_POSITIVE_POSITION_LIMIT: begin
                        param_rdata_r <= pos_limit_r;
                    end
                    default: begin
                        param_addr_err_r <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule // pst_segment_trigger

// *** pst_pkg.sv ***
// Package: constants and carrier types for the process segment trigger block
package pst_pkg;

    // ------
    // Parameter addresses (word addresses on the parameter link)
    // ------
    localparam logic [15:0] ADDR_SEGMENT_COMMAND_STATE       = 16'h2200;
    localparam logic [15:0] ADDR_RISING_EDGE_SEGMENT_SELECT  = 16'h2201;
    localparam logic [15:0] ADDR_FALLING_EDGE_SEGMENT_SELECT = 16'h2202;
    localparam logic [15:0] ADDR_PAUSE_RAMP_SELECT           = 16'h2203;
    localparam logic [15:0] ADDR_POSITIVE_POSITION_LIMIT     = 16'h2204;

    // ------
    // Reset values
    // ------
    localparam logic [15:0] RST_SEGMENT_COMMAND_STATE   = 16'h0000;
    localparam logic [15:0] RST_RISING_EDGE_SELECT      = 16'h0000;
    localparam logic [15:0] RST_FALLING_EDGE_SELECT     = 16'h0000;
    localparam logic [2:0]  RST_PAUSE_RAMP_SELECT       = 3'h0;
    localparam logic [31:0] RST_POSITIVE_POSITION_LIMIT = 32'h7FFFFFFF;

    // ------
    // Command codes and state offsets
    // ------
    localparam logic [15:0] CMD_HOMING       = 16'h0000;
    localparam logic [15:0] CMD_SEG_LAST     = 16'h000F;
    localparam logic [15:0] CMD_ERR_LAST     = 16'h03E7;
    localparam logic [15:0] CMD_PAUSE        = 16'h03E8;
    localparam logic [15:0] STATE_OFS_DONE   = 16'h2710;
    localparam logic [15:0] STATE_OFS_INPOS  = 16'h4E20;

    // ------
    // Field layout of the edge selector registers and pause ramp constants
    // ------
    localparam int SEL_FIELD_W    = 4;
    localparam int NUM_TRIGGERS   = 4;
    localparam int RAMP_SEL_W     = 3;
    localparam int RAMP_REF_RPM   = 1000;
    localparam logic [15:0] RAMP_SEL_MAX = 16'h0007;

    // Command from one source to the shared decoder
    typedef struct packed {
        logic        valid;
        logic [15:0] value;
    } pst_cmd_t;

    // One parameter access from the communication link
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } pst_param_req_t;

    // Motion request handed to the motion generator
    typedef struct packed {
        logic        homing;
        logic        start;
        logic        pause;
        logic [3:0]  seg_num;
    } pst_motion_req_t;

endpackage

// *** pst_segment_trigger_sva.sv ***
// Checker: command, readback, trigger and fault assertions
`timescale 1ns/1ps
module pst_segment_trigger_sva (
    input wire logic                     clk_sys,
    input wire logic                     reset_n,
    input wire pst_pkg::pst_param_req_t  param_req,
    input wire pst_pkg::pst_cmd_t        keypad_cmd,
    input wire logic                     pos_cmds_done,
    input wire logic                     positioning_complete,
    input wire logic                     segment_positioning,
    input wire logic [31:0]              position_ref,
    input wire logic                     fault_clear,
    input wire logic [31:0]              param_rdata_r,
    input wire logic                     param_rd_valid_r,
    input wire pst_pkg::pst_motion_req_t motion_req_r,
    input wire logic [2:0]               pause_ramp_sel_r,
    input wire logic [3:0]               active_seg_r,
    input wire logic                     segment_number_error_fault_r,
    input wire logic                     positive_overtravel_fault_r
);
    // ------
    // Shadow registers, kept from link writes only
    // ------
    logic [15:0] sel_rise_q, sel_fall_q;
    logic [2:0]  ramp_q;
    logic [31:0] lim_q;
    logic [15:0] rb_exp;
    wire [15:0]  wv      = param_req.wdata[15:0];
    wire [3:0]   wseg    = param_req.wdata[3:0];
    wire [3:0]   kseg    = keypad_cmd.value[3:0];
    wire         wcmd    = param_req.wr && param_req.addr == 16'h2200;
    wire         cmd_any = wcmd || keypad_cmd.valid;

    // Out-of-range ramp writes are dropped, as the design does
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sel_rise_q <= 16'h0000;
            sel_fall_q <= 16'h0000;
            ramp_q     <= 3'h0;
            lim_q      <= 32'h7FFFFFFF;
        end else if (param_req.wr) begin
            case (param_req.addr)
                16'h2201: sel_rise_q <= wv;
                16'h2202: sel_fall_q <= wv;
                16'h2203: if (wv <= 16'h0007) ramp_q <= wv[2:0];
                16'h2204: lim_q <= param_req.wdata;
                default: ;
            endcase
        end
    end

    // Expected readback from the levels at the read edge
    always_comb begin
        rb_exp = {12'h000, active_seg_r};
        if (pos_cmds_done)
            rb_exp = rb_exp + (positioning_complete ? 16'h4E20 : 16'h2710);
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    homing_start_a: assert property (
        wcmd && wv == 16'h0000 |=> motion_req_r.homing)
        else $error("homing not started");
    seg_start_a: assert property (
        wcmd && wv inside {[16'h0001:16'h000F]} |=> motion_req_r.start
        && motion_req_r.seg_num == $past(wseg))
        else $error("segment start wrong");
    pause_cmd_a: assert property (
        wcmd && wv == 16'h03E8 |=> motion_req_r.pause && !motion_req_r.start)
        else $error("pause missing");
    seg_error_a: assert property (
        wcmd && wv inside {[16'h0010:16'h03E7]}
        |=> segment_number_error_fault_r && !motion_req_r.start)
        else $error("number fault missing");
    fault_hold_a: assert property (
        segment_number_error_fault_r && !fault_clear
        |=> segment_number_error_fault_r)
        else $error("number fault not held");
    readback_a: assert property (
        param_req.rd && !param_req.wr && param_req.addr == 16'h2200
        |=> param_rd_valid_r && param_rdata_r == {16'h0000, $past(rb_exp)})
        else $error("readback value wrong");
    rd_idle_a: assert property (
        !param_req.rd |=> !param_rd_valid_r && param_rdata_r == 32'h0)
        else $error("read answer without request");
    no_sel_start_a: assert property (
        motion_req_r.start && sel_rise_q == 16'h0 && sel_fall_q == 16'h0
        |-> $past(cmd_any))
        else $error("start with no cause");
    ramp_latch_a: assert property (
        motion_req_r.pause |-> pause_ramp_sel_r == $past(ramp_q))
        else $error("pause ramp index wrong");
    overtravel_a: assert property (
        segment_positioning && $signed(position_ref) > $signed(lim_q)
        |=> positive_overtravel_fault_r)
        else $error("overtravel fault missing");
    keypad_start_a: assert property (
        keypad_cmd.valid && !wcmd && keypad_cmd.value inside {[1:15]}
        |=> motion_req_r.start && motion_req_r.seg_num == $past(kseg))
        else $error("keypad start lost");

    cover property (motion_req_r.start);
    cover property (motion_req_r.pause);
    cover property (positive_overtravel_fault_r);
endmodule // pst_segment_trigger_sva

bind pst_segment_trigger pst_segment_trigger_sva i_sva (
    .clk_sys(clk_sys), .reset_n(reset_n), .param_req(param_req),
    .keypad_cmd(keypad_cmd), .pos_cmds_done(pos_cmds_done),
    .positioning_complete(positioning_complete),
    .segment_positioning(segment_positioning),
    .position_ref(position_ref), .fault_clear(fault_clear),
    .param_rdata_r(param_rdata_r), .param_rd_valid_r(param_rd_valid_r),
    .motion_req_r(motion_req_r), .pause_ramp_sel_r(pause_ramp_sel_r),
    .active_seg_r(active_seg_r),
    .segment_number_error_fault_r(segment_number_error_fault_r),
    .positive_overtravel_fault_r(positive_overtravel_fault_r)
);

// *** pst_host_model.sv ***
// Partner: host controller issuing parameter reads and writes
`timescale 1ns/1ps
module pst_host_model (
    input  wire logic               clk_sys,
    output pst_pkg::pst_param_req_t param_req,
    input  wire logic [31:0]        param_rdata_r,
    input  wire logic               param_rd_valid_r,
    input  wire logic               param_addr_err_r
);
    initial param_req = '0;

    // One-cycle strobe; released lines show inverted junk, not old data
    task automatic put(input logic w, input logic [15:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        param_req <= '{wr: w, rd: ~w, addr: a, wdata: d};
        @(posedge clk_sys);
        param_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        put(1'b1, a, d);
    endtask

    // Answer stands one cycle after the taking edge
    task automatic rd(input logic [15:0] a, output logic [31:0] d,
                      output logic e);
        put(1'b0, a, 32'h0);
        @(posedge clk_sys);
        d = (param_rd_valid_r === 1'b1) ? param_rdata_r : 'x;
        e = param_addr_err_r;
    endtask
endmodule // pst_host_model

// *** tb_process_segment_trigger.sv ***
// Testbench: self-checking scenarios for the segment trigger block
`timescale 1ns/1ps
module tb_process_segment_trigger;
    logic                     clk_sys, reset_n, fault_clear;
    logic                     pos_cmds_done, positioning_complete;
    logic                     segment_positioning, rd_valid, addr_err;
    logic                     seg_err, ot_err;
    logic [3:0]               trig_in, active_seg;
    logic [31:0]              position_ref, rdata;
    logic [2:0]               ramp_sel;
    pst_pkg::pst_param_req_t  param_req;
    pst_pkg::pst_cmd_t        keypad_cmd;
    pst_pkg::pst_motion_req_t mreq;
    int                       num_errors = 0;
    int                       checked = 0;

    pst_host_model i_host (.clk_sys(clk_sys), .param_req(param_req),
        .param_rdata_r(rdata), .param_rd_valid_r(rd_valid),
        .param_addr_err_r(addr_err));
    pst_segment_trigger i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .param_req(param_req), .keypad_cmd(keypad_cmd),
        .segment_event_trigger_input(trig_in),
        .pos_cmds_done(pos_cmds_done),
        .positioning_complete(positioning_complete),
        .segment_positioning(segment_positioning),
        .position_ref(position_ref), .fault_clear(fault_clear),
        .param_rdata_r(rdata), .param_rd_valid_r(rd_valid),
        .param_addr_err_r(addr_err), .motion_req_r(mreq),
        .pause_ramp_sel_r(ramp_sel), .active_seg_r(active_seg),
        .segment_number_error_fault_r(seg_err),
        .positive_overtravel_fault_r(ot_err));

    // ------
    // Clock, verdict and shared helpers
    // ------
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic complete_run();
        if (num_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Keypad strobe; outcome is visible when this returns
    task automatic keypad(input logic [15:0] v);
        keypad_cmd <= '{valid: 1'b1, value: v};
        @(posedge clk_sys);
        keypad_cmd <= '{valid: 1'b0, value: ~v};
        @(posedge clk_sys);
    endtask

    // One pin edge, then count starts over a window past the sync delay
    task automatic edge_at(input int pin, input logic lvl,
                           input logic [3:0] exp);
        int         n;
        logic [3:0] seg;
        n = 0;
        seg = 4'h0;
        trig_in[pin] <= lvl;
        repeat (8) begin
            @(posedge clk_sys);
            if (mreq.start === 1'b1) begin
                n++;
                seg = mreq.seg_num;
            end
        end
        check(32'(n), 32'(exp != 4'h0));
        check(32'(seg), 32'(exp));
    endtask

    // ------
    // Scenarios
    // ------
    task automatic t_regs();
        logic [31:0] d;
        logic        e;
        for (int a = 0; a < 5; a++) begin
            i_host.rd(16'h2200 + 16'(a), d, e);
            check(d, (a == 4) ? 32'h7FFFFFFF : 32'h0);
        end
        i_host.rd(16'h2205, d, e);
        check(32'(e), 32'h1);
        i_host.wr(16'h2203, 32'h8);
        i_host.rd(16'h2203, d, e);
        check(d, 32'h0);
    endtask

    // Codes 0 to 15 with readback under each completion level, then 16, 999, 1000, 1001
    task automatic t_cmd();
        logic [31:0] d;
        logic        e;
        int          bad[4] = '{16, 999, 1000, 1001};
        for (int v = 0; v < 16; v++) begin
            pos_cmds_done <= v[0];
            positioning_complete <= v[1];
            i_host.wr(16'h2200, 32'(v));
            @(posedge clk_sys);
            check({mreq.homing, mreq.start, mreq.seg_num, active_seg},
                  {v == 0, v != 0, 4'(v), 4'(v)});
            i_host.rd(16'h2200, d, e);
            check(d, 32'(v + (v[0] ? (v[1] ? 20000 : 10000) : 0)));
        end
        foreach (bad[i]) begin
            i_host.wr(16'h2200, 32'(bad[i]));
            @(posedge clk_sys);
            check({mreq.start, mreq.pause, seg_err},
                  {1'b0, bad[i] == 1000, bad[i] < 1000});
            fault_clear <= 1'b1;
            @(posedge clk_sys);
            fault_clear <= 1'b0;
        end
    endtask

    // Pause ramp index per setting; 8 is refused and 7 stays
    task automatic t_ramp();
        for (int r = 0; r < 9; r++) begin
            i_host.wr(16'h2203, 32'(r));
            keypad(16'h03E8);
            check({mreq.pause, ramp_sel}, {1'b1, 3'(r > 7 ? 7 : r)});
        end
        keypad(16'h0009);
        check({mreq.start, mreq.seg_num}, {1'b1, 4'h9});
    endtask

    task automatic t_trig();
        logic [15:0] rs, fs;
        rs = 16'h0A05;
        fs = 16'hC030;
        i_host.wr(16'h2201, {16'h0, rs});
        i_host.wr(16'h2202, {16'h0, fs});
        for (int i = 0; i < 4; i++)
            edge_at(i, 1'b1, rs[i*4 +: 4]);
        for (int i = 0; i < 4; i++)
            edge_at(i, 1'b0, fs[i*4 +: 4]);
    endtask

    // Signed compare: negative reference and equality must not trip
    task automatic t_ot();
        logic [31:0] refs[3] = '{32'h80000000, 32'h100, 32'h101};
        i_host.wr(16'h2204, 32'h100);
        segment_positioning <= 1'b1;
        foreach (refs[i]) begin
            position_ref <= refs[i];
            repeat (2) @(posedge clk_sys);
            check(32'(ot_err), 32'(i == 2));
        end
        fault_clear <= 1'b1;
        segment_positioning <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check(32'(ot_err), 32'h0);
    endtask

    // Main sequence; inputs set at time zero, reset held 20 cycles
    initial begin
        reset_n = 1'b0;
        fault_clear = 1'b0;
        pos_cmds_done = 1'b0;
        positioning_complete = 1'b0;
        segment_positioning = 1'b0;
        trig_in = 4'h0;
        position_ref = 32'h0;
        keypad_cmd = '0;
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_cmd();
        t_ramp();
        t_trig();
        t_ot();
        complete_run();
    end

    // Watchdog at 20000 cycles; the run needs well under 2000
    initial begin
        #2000000;
        num_errors++;
        complete_run();
    end
endmodule // tb_process_segment_trigger
